// [logic/swrp_pkg.sv]
// package: register map, field positions, reset values and carriers for the serial write port
`default_nettype none
package swrp_pkg;
    // register addresses
    localparam logic [7:0] ADDR_RESET   = 8'h1a;
    localparam logic [7:0] ADDR_GENERAL = 8'h1b;
    localparam logic [7:0] ADDR_GAIN    = 8'h1c;
    localparam logic [7:0] ADDR_MODE    = 8'h1d;
    localparam logic [7:0] ADDR_OFFSET  = 8'h1f;
    localparam logic [7:0] ADDR_IMOD    = 8'h2f;
    // reset values
    localparam logic [7:0] RST_VALUE    = 8'h00;
    // field positions
    localparam int GEN_DIV_BIT   = 7;
    localparam int GEN_BIAS_BIT  = 4;
    localparam int GEN_DEMOD_BIT = 1;
    localparam int GAIN_DRV_BIT  = 7;
    localparam int GAIN_COR_BIT  = 6;
    localparam int GAIN_FB_LSB   = 2;
    localparam int GAIN_BB_LSB   = 0;
    localparam int MODE_CH_LSB   = 6;
    localparam int MODE_LO_LSB   = 0;
    localparam int OFS_I_LSB     = 0;
    localparam int OFS_Q_LSB     = 4;
    localparam int IMOD_LSB      = 2;
    // framing
    localparam int BYTE_BITS     = 8;

    // decoded register contents
    typedef struct packed {
        logic [7:0] general;
        logic [7:0] gain;
        logic [7:0] mode;
        logic [7:0] offset;
        logic [7:0] imod;
    } swrp_regs_s;

    // received byte from the shifter
    typedef struct packed {
        logic       isAddr;
        logic [7:0] value;
    } swrp_byte_s;
endpackage
`default_nettype wire

// [logic/swrp_sync.sv]
// module: two-flop synchroniser for a single input pin
`default_nettype none
module swrp_sync
    import swrp_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // pin and synced level
    input  wire logic pinIn,
    output logic      syncOut
);
    logic stage1;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            stage1  <= 1'b1;
            syncOut <= 1'b1;
        end
        else if (clkEn)
        begin
            stage1  <= pinIn;
            syncOut <= stage1;
        end
    end
endmodule
`default_nettype wire

// [logic/swrp_shifter.sv]
// module: msb-first byte shifter framed by select, clocked on serial clock rising edges
`default_nettype none
module swrp_shifter
    import swrp_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // synced serial pins
    input  wire logic sclkRise,
    input  wire logic selectN,
    input  wire logic dataBit,
    // received byte
    output var swrp_byte_s rxByte,
    output logic           rxValid
);
    logic [6:0] shiftReg;
    logic [2:0] bitCount;
    logic       haveAddr;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            shiftReg <= 7'h00;
            bitCount <= 3'h0;
            haveAddr <= 1'b0;
            rxByte   <= '0;
            rxValid  <= 1'b0;
        end
        else if (clkEn)
        begin
            rxValid <= 1'b0;
            if (selectN)
            begin
                bitCount <= 3'h0;
                haveAddr <= 1'b0;
            end
            else if (sclkRise)
            begin
                shiftReg <= {shiftReg[5:0], dataBit};
                bitCount <= bitCount + 3'h1;
                if (bitCount == 3'h7)
                begin
                    rxByte.value  <= {shiftReg, dataBit};
                    rxByte.isAddr <= ~haveAddr;
                    rxValid       <= 1'b1;
                    haveAddr      <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [logic/swrp_port.sv]
// module: serial write-only control port and its register bank
`default_nettype none
// Summary of operation
// - a transaction is one address byte, optionally followed by any number of data bytes, each written into that register
// - serial data is sampled on each rising edge of the serial clock
// - every address has a fixed direction; none is both readable and writable
// - only write registers exist; the read-data line is never driven
// - address 1a is a data-less reset command, acted on from the address alone
// - general, gain/output and mode registers decode at 1b, 1c, 1d
// - offset correction register decodes at 1f
// - registers keep their contents while the digital supply stays up
// - gain register bit 6 enables quadrature phase correction
// - gain register bit 7 selects output drive strength and bandwidth
// - register 2f holds the mixer intermodulation tuning bits
// - lo tuning field resets to 0000; host writes 1111 with correction on
// - i and q channels each carry their own offset correction value
// - each channel sums 60, 120, 180 mv sources of either polarity
// - addresses not owned by this device are ignored for shared wiring
// - reset command clears every register and enters powersave
// - port disabled holds registers in reset, forcing bias and demod enables
module swrp_port
    import swrp_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // serial pins
    input  wire logic serialClk,
    input  wire logic serial_cmd_in,
    input  wire logic select_n,
    input  wire logic port_disable_n,
    // read-data pin
    output logic      readData,
    output logic      readDataOe,
    // decoded controls
    output logic      lo_div_two,
    output logic      bias_enable,
    output logic      demod_enable,
    output logic      powersave,
    output logic      output_drive_boost,
    output logic      phase_correct_enable,
    output logic [2:0] front_gain,
    output logic [1:0] baseband_gain,
    output logic [1:0] channel_select,
    output logic [3:0] lo_level_tune,
    output logic [3:0] offsetI,
    output logic [3:0] offsetQ,
    output logic [5:0] intermod_tune
);
    // ********************************
    // pin synchronisers
    // ********************************
    logic sclkSync;
    logic dataSync;
    logic selSync;
    logic disSync;
    logic sclkLast;
    logic sclkRise;

    swrp_sync u_syncClk
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .pinIn   (serialClk),
        .syncOut (sclkSync)
    );
    swrp_sync u_syncData
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .pinIn   (serial_cmd_in),
        .syncOut (dataSync)
    );
    swrp_sync u_syncSel
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .pinIn   (select_n),
        .syncOut (selSync)
    );
    swrp_sync u_syncDis
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .pinIn   (port_disable_n),
        .syncOut (disSync)
    );

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            sclkLast <= 1'b1;
        else if (clkEn)
            sclkLast <= sclkSync;
    end

    assign sclkRise = sclkSync & ~sclkLast;

    // ********************************
    // byte receiver
    // ********************************
    swrp_byte_s rxByte;
    logic       rxValid;

    swrp_shifter u_shifter
    (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .sclkRise (sclkRise),
        .selectN  (selSync | ~disSync),
        .dataBit  (dataSync),
        .rxByte   (rxByte),
        .rxValid  (rxValid)
    );

    // ********************************
    // address decode and register bank
    // ********************************
    logic [7:0] curAddr;
    logic       addrOwned;
    logic       resetCmd;
    swrp_regs_s regs;

    // owned data addresses only; the reset address takes no data
    assign addrOwned = (curAddr == ADDR_GENERAL) || (curAddr == ADDR_GAIN) || (curAddr == ADDR_MODE)
                    || (curAddr == ADDR_OFFSET) || (curAddr == ADDR_IMOD);
    assign resetCmd  = rxValid && rxByte.isAddr && (rxByte.value == ADDR_RESET);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            curAddr <= 8'h00;
        else if (clkEn && rxValid && rxByte.isAddr)
            curAddr <= rxByte.value;
    end

    // contents persist while powered; sys_rst, port disable and the reset command clear them
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !disSync || resetCmd)
            regs <= {5{RST_VALUE}};
        else if (clkEn && rxValid && !rxByte.isAddr && addrOwned)
        begin
            unique case (curAddr)
                ADDR_GENERAL: regs.general <= rxByte.value;
                ADDR_GAIN:    regs.gain    <= rxByte.value;
                ADDR_MODE:    regs.mode    <= rxByte.value;
                ADDR_OFFSET:  regs.offset  <= rxByte.value;
                ADDR_IMOD:    regs.imod    <= rxByte.value;
                default:      regs         <= regs;
            endcase
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign readData   = 1'b0;
    assign readDataOe = 1'b0;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            lo_div_two           <= 1'b0;
            bias_enable          <= 1'b0;
            demod_enable         <= 1'b0;
            powersave            <= 1'b1;
            output_drive_boost   <= 1'b0;
            phase_correct_enable <= 1'b0;
            front_gain           <= 3'h0;
            baseband_gain        <= 2'h0;
            channel_select       <= 2'h0;
            lo_level_tune        <= 4'h0;
            offsetI              <= 4'h0;
            offsetQ              <= 4'h0;
            intermod_tune        <= 6'h00;
        end
        else if (clkEn)
        begin
            lo_div_two           <= regs.general[GEN_DIV_BIT];
            bias_enable          <= regs.general[GEN_BIAS_BIT] | ~disSync;
            demod_enable         <= regs.general[GEN_DEMOD_BIT] | ~disSync;
            powersave            <= ~(regs.general[GEN_BIAS_BIT] | ~disSync);
            output_drive_boost   <= regs.gain[GAIN_DRV_BIT];
            phase_correct_enable <= regs.gain[GAIN_COR_BIT];
            front_gain           <= regs.gain[GAIN_FB_LSB +: 3];
            baseband_gain        <= regs.gain[GAIN_BB_LSB +: 2];
            channel_select       <= regs.mode[MODE_CH_LSB +: 2];
            lo_level_tune        <= regs.mode[MODE_LO_LSB +: 4];
            offsetI              <= regs.offset[OFS_I_LSB +: 4];
            offsetQ              <= regs.offset[OFS_Q_LSB +: 4];
            intermod_tune        <= regs.imod[IMOD_LSB +: 6];
        end
    end

    // ********************************
    // assertions
    // ********************************
    a_read_idle: assert property (@(posedge clk_sys) disable iff (sys_rst) !readDataOe)
        else $error("read line driven");
    a_reset_cmd: assert property (@(posedge clk_sys) disable iff (sys_rst)
        resetCmd |=> (regs == '0))
        else $error("reset command left registers set");
    a_disable_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !disSync |=> (regs == '0))
        else $error("registers not held while disabled");
    a_disable_force: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (clkEn && !disSync) |=> (bias_enable && demod_enable))
        else $error("bias or demod not forced");
    a_gain_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (clkEn && disSync && rxValid && !rxByte.isAddr && curAddr == ADDR_GAIN)
        |=> (regs.gain == $past(rxByte.value)))
        else $error("gain write lost");
    a_offset_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (clkEn && disSync && rxValid && !rxByte.isAddr && curAddr == ADDR_OFFSET)
        |=> (regs.offset == $past(rxByte.value)))
        else $error("offset write lost");
    a_general_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (clkEn && disSync && rxValid && !rxByte.isAddr && curAddr == ADDR_GENERAL)
        |=> (regs.general == $past(rxByte.value)))
        else $error("general write lost");
    a_mode_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (clkEn && disSync && rxValid && !rxByte.isAddr && curAddr == ADDR_MODE)
        |=> (regs.mode == $past(rxByte.value)))
        else $error("mode write lost");
    a_imod_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (clkEn && disSync && rxValid && !rxByte.isAddr && curAddr == ADDR_IMOD)
        |=> (regs.imod == $past(rxByte.value)))
        else $error("intermod write lost");
    a_drive_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn |=> (output_drive_boost == $past(regs.gain[GAIN_DRV_BIT])))
        else $error("output drive mismatch");
    a_lo_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn |=> (lo_level_tune == $past(regs.mode[MODE_LO_LSB +: 4])))
        else $error("lo tuning mismatch");
    a_unmapped_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (disSync && !resetCmd && !(rxValid && !rxByte.isAddr && addrOwned)) |=> $stable(regs))
        else $error("registers changed without a write");
    a_cor_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn |=> (phase_correct_enable == $past(regs.gain[GAIN_COR_BIT])))
        else $error("phase correct enable mismatch");

    c_reset_cmd:  cover property (@(posedge clk_sys) resetCmd);
    c_gain_write: cover property (@(posedge clk_sys) rxValid && !rxByte.isAddr && curAddr == ADDR_GAIN);
    c_disabled:   cover property (@(posedge clk_sys) !disSync);
endmodule
`default_nettype wire

// [tb/swrp_host_model.sv]
// host serial controller model driving the write port pins
`default_nettype none
module swrp_host_model
(
    // clock
    input  wire logic clk_sys,
    // serial pins
    output logic      serialClk,
    output logic      serialData,
    output logic      selectN
);
    timeunit 1ns;
    timeprecision 100ps;
    // half serial period in clk_sys cycles: 40 ns
    localparam int HALF_CLKS = 5;
    initial
    begin
        serialClk = 1'b0;
        serialData = 1'b1;
        selectN = 1'b1;
    end
    task automatic half_wait();
        repeat (HALF_CLKS) @(posedge clk_sys);
        #1;
    endtask
    // send nBits of frame msb first; fewer than 16 cuts a transfer short
    task automatic send(input logic [15:0] frame, input int nBits);
        half_wait();
        selectN = 1'b0;
        for (int b = 15; b > 15 - nBits; b--)
        begin
            serialData = frame[b];
            half_wait();
            serialClk = 1'b1;
            half_wait();
            serialClk = 1'b0;
        end
        serialData = ~serialData;
        half_wait();
        selectN = 1'b1;
        half_wait();
    endtask
endmodule
`default_nettype wire

// [tb/test_serial_write_register_port.sv]
// testbench: serial write port driven through the host model
`default_nettype none
`define SWRP_CHECK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module test_serial_write_register_port
    import swrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys, sys_rst, portDisableN, clkEn;
    logic       serialClk, serialData, selectN;
    logic       readData, readDataOe, lo_div_two, bias_enable, demod_enable, powersave;
    logic       output_drive_boost, phase_correct_enable;
    logic [2:0] front_gain;
    logic [1:0] baseband_gain, channel_select;
    logic [3:0] lo_level_tune, offsetI, offsetQ;
    logic [5:0] intermod_tune;
    logic [7:0] expGen, expGain, expMode, expOfs, expImod;
    int         n_mismatch = 0;
    int         checks_done = 0;

    swrp_host_model u_host (.clk_sys(clk_sys), .serialClk(serialClk), .serialData(serialData),
        .selectN(selectN));
    swrp_port u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .serialClk(serialClk),
        .serial_cmd_in(serialData), .select_n(selectN), .port_disable_n(portDisableN),
        .readData(readData), .readDataOe(readDataOe), .lo_div_two(lo_div_two),
        .bias_enable(bias_enable), .demod_enable(demod_enable), .powersave(powersave),
        .output_drive_boost(output_drive_boost), .phase_correct_enable(phase_correct_enable),
        .front_gain(front_gain), .baseband_gain(baseband_gain), .channel_select(channel_select),
        .lo_level_tune(lo_level_tune), .offsetI(offsetI), .offsetQ(offsetQ),
        .intermod_tune(intermod_tune));

    always #4 clk_sys = ~clk_sys;

    // ********************************
    // shared tasks
    // ********************************
    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check_outs(input logic [7:0] g, c, m, o, i);
        repeat (12) @(posedge clk_sys);
        #1;
        `SWRP_CHECK("readDataOe", 1'b0, readDataOe)
        `SWRP_CHECK("readData", 1'b0, readData)
        `SWRP_CHECK("lo_div_two", g[7], lo_div_two)
        `SWRP_CHECK("bias_enable", g[4], bias_enable)
        `SWRP_CHECK("demod_enable", g[1], demod_enable)
        `SWRP_CHECK("powersave", ~g[4], powersave)
        `SWRP_CHECK("output_drive_boost", c[7], output_drive_boost)
        `SWRP_CHECK("phase_correct_enable", c[6], phase_correct_enable)
        `SWRP_CHECK("front_gain", c[4:2], front_gain)
        `SWRP_CHECK("baseband_gain", c[1:0], baseband_gain)
        `SWRP_CHECK("channel_select", m[7:6], channel_select)
        `SWRP_CHECK("lo_level_tune", m[3:0], lo_level_tune)
        `SWRP_CHECK("offsetI", o[3:0], offsetI)
        `SWRP_CHECK("offsetQ", o[7:4], offsetQ)
        `SWRP_CHECK("intermod_tune", i[7:2], intermod_tune)
    endtask
    task automatic check_shadow();
        check_outs(expGen, expGain, expMode, expOfs, expImod);
    endtask
    task automatic clear_shadow();
        {expGen, expGain, expMode, expOfs, expImod} = '0;
    endtask
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        u_host.send({addr, data}, 16);
        case (addr)
            ADDR_GENERAL: expGen = data;
            ADDR_GAIN: expGain = data;
            ADDR_MODE: expMode = data;
            ADDR_OFFSET: expOfs = data;
            ADDR_IMOD: expImod = data;
            default: ;
        endcase
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic test_all_registers();
        write_reg(ADDR_GENERAL, 8'h92);
        write_reg(ADDR_GAIN, 8'hd6);
        write_reg(ADDR_MODE, 8'h4f);
        write_reg(ADDR_OFFSET, 8'h9e);
        write_reg(ADDR_IMOD, 8'hfc);
        check_shadow();
    endtask
    task automatic test_lo_codes();
        logic [3:0] codes [5] = '{4'h4, 4'h8, 4'hc, 4'hd, 4'he};
        foreach (codes[k])
        begin
            write_reg(ADDR_MODE, {4'h8, codes[k]});
            check_shadow();
        end
    endtask
    task automatic test_ignored();
        write_reg(8'h10, 8'hff);
        write_reg(8'h1e, 8'hff);
        write_reg(8'h2e, 8'h00);
        u_host.send({ADDR_GAIN, 8'h01}, 12);
        u_host.send({ADDR_OFFSET, 8'h00}, 8);
        repeat (200) @(posedge clk_sys);
        check_shadow();
    endtask
    task automatic test_clock_freeze();
        @(posedge clk_sys);
        #1 clkEn = 1'b0;
        u_host.send({ADDR_GAIN, 8'h3c}, 16);
        @(posedge clk_sys);
        #1 clkEn = 1'b1;
        check_shadow();
    endtask
    task automatic test_reset_command();
        u_host.send({ADDR_RESET, 8'h00}, 8);
        clear_shadow();
        check_shadow();
    endtask
    task automatic test_port_disable();
        write_reg(ADDR_GAIN, 8'h80);
        write_reg(ADDR_GENERAL, 8'h80);
        @(posedge clk_sys);
        #1 portDisableN = 1'b0;
        check_outs(8'h12, 8'h00, 8'h00, 8'h00, 8'h00);
        u_host.send({ADDR_GAIN, 8'hff}, 16);
        check_outs(8'h12, 8'h00, 8'h00, 8'h00, 8'h00);
        @(posedge clk_sys);
        #1 portDisableN = 1'b1;
        clear_shadow();
        check_shadow();
    endtask

    initial
    begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        portDisableN = 1'b1;
        clkEn = 1'b1;
        clear_shadow();
        repeat (20) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        check_shadow();
        test_all_registers();
        test_clock_freeze();
        test_lo_codes();
        test_ignored();
        test_reset_command();
        test_all_registers();
        test_port_disable();
        complete_run();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
